/* File: speed_ref_cfg.svh */
// Offsets, field layouts, reset values and timing counts of the speed reference block
`ifndef SPEED_REF_CFG_SVH
`define SPEED_REF_CFG_SVH
// Register byte addresses
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_RATIO_COEF 12'h008
`define REG_RATIO_BIAS 12'h00c
`define REG_EXTRA_BIAS 12'h010
`define REG_RAMP_ACC1 12'h014
`define REG_RAMP_DEC1 12'h018
`define REG_RAMP_ACC2 12'h01c
`define REG_RAMP_DEC2 12'h020
`define REG_RAMP_JOGA 12'h024
`define REG_RAMP_JOGD 12'h028
`define REG_SCURVE 12'h02c
`define REG_TIME_UNIT 12'h030
`define REG_SKIP_LO 12'h034
`define REG_SKIP_HI 12'h038
`define REG_SETTING_IN 12'h03c
`define REG_COMMAND 12'h040
`define REG_BIAS_BUF 12'h044
`define REG_TM1 12'h048
`define REG_TM2 12'h04c
`define REG_TM_SEL 12'h050
`define REG_PRESET0 12'h080
// Control register fields
`define CTRL_SEL_MODE_LSB 0
`define CTRL_VF_BIT 2
`define CTRL_RESET 32'h0000_0001
// Selection mode codes
`define SEL_MODE_BINARY 2'h1
`define SEL_MODE_DIRECT 2'h2
// Time unit codes
`define UNIT_X1 2'h1
`define UNIT_X0_1 2'h2
`define UNIT_X10 2'h3
// Ramp time base: ramp setting units are 100 ms, clock is 100 ns
`define CLOCK_PERIOD_NS 100
`define RAMP_UNIT_MS 100
`define RAMP_UNIT_CYCLES ((`RAMP_UNIT_MS * 1000000) / `CLOCK_PERIOD_NS)
// Full scale of frequency in percent times 100
`define FULL_SCALE 32'd10000
`define RAMP_TIME_RESET 16'h0064
`endif

/* File: speed_ref_pkg.sv */
// Types shared by the speed reference block
package speed_ref_pkg;
  // Sequence inputs from the external controller
  typedef struct packed {
    logic run;
    logic jog;
    logic bias_trim_enable;
    logic bias_raise;
    logic bias_lower;
    logic alt_ramp_choose;
    logic fixed_speed_enable;
    logic preset_line_0;
    logic preset_line_1;
    logic preset_line_2;
    logic preset_line_3;
    logic upper_group_line;
    logic inertia_alt_pick;
  } seq_in_t;
  // Ramp direction of the output follower
  typedef enum logic [1:0] {RAMP_IDLE, RAMP_UP, RAMP_DOWN} ramp_dir_t;
endpackage : speed_ref_pkg

/* File: speed_reference_generator.sv */
// Speed reference generator: preset pick, ratio bias, bias trim, ramp and skip band
//
// Function
// - Command equals coefficient times input plus biases
// - Trim raise grows bias at accel rate
// - Trim lower shrinks bias at decel rate
// - No raise or lower holds bias
// - Trim disabled clears bias, ignores inputs
// - Run off clears bias, ignores inputs
// - Bias buffer adds to ratio bias
// - Alternate select uses second ramp set unless jogging
// - Jogging uses own jog ramp times
// - Ramp time spans zero to maximum
// - S-curve shapes ramps, step grows to two, total time shorter
// - Unit code scales ramps: x1, x0.1, x10
// - Eight percent presets under fixed speed
// - Binary mode uses three low lines
// - Direct mode single line, upper group
// - In direct mode no line holds latest, cleared at reset
// - V/f keeps setting outside skip band
// - Changeover active picks time constant two
// - Changeover inactive picks time constant one
`include "speed_ref_cfg.svh"

module speed_reference_generator #(
  parameter int unsigned RAMP_UNIT_CYC = `RAMP_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequence inputs
  input speed_ref_pkg::seq_in_t seq,
  // Command outputs
  output logic [15:0] speed_command,
  output logic [15:0] active_time_const
);
  import speed_ref_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] coef;          // Coefficient, 8.8 fixed point
    logic [15:0] ratio_bias;
    logic [15:0] extra_bias;
    logic [15:0] acc1;
    logic [15:0] dec1;
    logic [15:0] acc2;
    logic [15:0] dec2;
    logic [15:0] jog_acc;
    logic [15:0] jog_dec;
    logic [15:0] scurve;
    logic [1:0] unit;
    logic [15:0] skip_lo;
    logic [15:0] skip_hi;
    logic [15:0] setting_in;
    logic [15:0] tm1;
    logic [15:0] tm2;
    logic [7:0][15:0] preset;
    logic [2:0] latest;         // Latest preset index
    logic [15:0] bias_buf;      // Trim bias, signed
    logic [31:0] bias_acc;      // Trim step accumulator
    logic [31:0] ramp_acc;      // Output step accumulator
    logic [15:0] out_ff;
    logic [15:0] slope;         // Current step size for S shaping
    ramp_dir_t dir;
    logic [31:0] rdata;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;

  // Decoded APB strobes
  logic wr_en;
  logic rd_en;
  logic hit;
  // Derived values
  logic [15:0] acc_t;
  logic [15:0] dec_t;
  logic [31:0] acc_scaled;
  logic [31:0] dec_scaled;
  logic [15:0] base_in;
  logic [31:0] target_wide;
  logic [15:0] target;
  logic [15:0] skipped;
  logic [2:0] pick;
  logic pick_ok;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  // No wait states: the register file answers in the access cycle
  assign pready = 1'b1;
  // Unmapped offsets answer with an error; writes to them are dropped
  assign pslverr = psel & penable & ~hit;
  assign prdata = cur_ff.rdata;
  assign speed_command = cur_ff.out_ff;

  // ------------------------------------------------------------
  // Ramp time scaling
  // ------------------------------------------------------------
  // Scale a ramp time by the unit code; result in tenths of units
  function automatic logic [31:0] scale_time(input logic [15:0] t, input logic [1:0] u);
    logic [31:0] r;
    r = {16'h0000, t} * 32'd10;
    case (u)
      `UNIT_X0_1: r = {16'h0000, t};
      `UNIT_X10: r = {16'h0000, t} * 32'd100;
      default: r = {16'h0000, t} * 32'd10;
    endcase
    return r;
  endfunction : scale_time

  // Pick ramp set: jog first, then alternate, then normal
  always_comb begin
    if (seq.jog) begin
      acc_t = cur_ff.jog_acc;
      dec_t = cur_ff.jog_dec;
    end else if (seq.alt_ramp_choose) begin
      acc_t = cur_ff.acc2;
      dec_t = cur_ff.dec2;
    end else begin
      acc_t = cur_ff.acc1;
      dec_t = cur_ff.dec1;
    end
  end

  // Cycles per full-scale sweep divided by full scale gives cycles per step;
  // we accumulate full scale per cycle instead, which avoids a divider.
  assign acc_scaled = scale_time(acc_t, cur_ff.unit) * (RAMP_UNIT_CYC / 10);
  assign dec_scaled = scale_time(dec_t, cur_ff.unit) * (RAMP_UNIT_CYC / 10);

  // ------------------------------------------------------------
  // Preset selection
  // ------------------------------------------------------------
  // Mode codes 0 and 3 pick nothing, so the latest preset stays
  always_comb begin
    pick = cur_ff.latest;
    pick_ok = 1'b0;
    if (cur_ff.ctrl[`CTRL_SEL_MODE_LSB +: 2] == `SEL_MODE_BINARY) begin
      pick = {seq.preset_line_2, seq.preset_line_1, seq.preset_line_0};
      pick_ok = 1'b1;
    end else if (cur_ff.ctrl[`CTRL_SEL_MODE_LSB +: 2] == `SEL_MODE_DIRECT) begin
      pick_ok = 1'b1;
      case ({seq.preset_line_3, seq.preset_line_2, seq.preset_line_1, seq.preset_line_0})
        4'h1: pick = {seq.upper_group_line, 2'h0};
        4'h2: pick = {seq.upper_group_line, 2'h1};
        4'h4: pick = {seq.upper_group_line, 2'h2};
        4'h8: pick = {seq.upper_group_line, 2'h3};
        default: pick = cur_ff.latest;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Ratio interlock and skip band
  // ------------------------------------------------------------
  // Fixed speed replaces the setting input by the picked preset
  assign base_in = seq.fixed_speed_enable ? cur_ff.preset[pick] : cur_ff.setting_in;
  always_comb begin
    logic signed [33:0] sum;
    sum = 34'sd0;
    // Y = A*X + (B' + B'') + C, clamped to 0..full scale
    sum = $signed({2'b00, ({16'h0000, base_in} * {16'h0000, cur_ff.coef}) >> 8})
        + $signed({{18{cur_ff.ratio_bias[15]}}, cur_ff.ratio_bias})
        + $signed({{18{cur_ff.bias_buf[15]}}, cur_ff.bias_buf})
        + $signed({{18{cur_ff.extra_bias[15]}}, cur_ff.extra_bias});
    if (sum < 34'sd0) begin
      target_wide = 32'h0000_0000;
    end else if (sum > $signed({2'b00, `FULL_SCALE})) begin
      target_wide = `FULL_SCALE;
    end else begin
      target_wide = sum[31:0];
    end
  end
  assign target = target_wide[15:0];

  // In V/f the target leaves the band by the nearer edge; ramp crosses it
  always_comb begin
    skipped = target;
    if (cur_ff.ctrl[`CTRL_VF_BIT] && target > cur_ff.skip_lo && target < cur_ff.skip_hi) begin
      skipped = (target - cur_ff.skip_lo < cur_ff.skip_hi - target) ?
                cur_ff.skip_lo : cur_ff.skip_hi;
    end
  end

  // Machine time constant for the speed loop gain
  // Switching is immediate; the speed loop must tolerate the jump
  assign active_time_const = seq.inertia_alt_pick ? cur_ff.tm2 : cur_ff.tm1;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] step_acc;
    logic [15:0] step;
    logic [15:0] smax;
    nxt_cur = cur_ff;
    step_acc = 32'h0;
    step = 16'h0;
    smax = 16'h0;
    hit = 1'b1;
    // Latest preset follows every valid pick
    if (pick_ok) begin
      nxt_cur.latest = pick;
    end
    // Bias trim buffer
    if (!seq.bias_trim_enable || !seq.run) begin
      nxt_cur.bias_buf = 16'h0000;
      nxt_cur.bias_acc = 32'h0;
    end else if (seq.bias_raise && !seq.bias_lower) begin
      step_acc = cur_ff.bias_acc + `FULL_SCALE;
      if (step_acc >= acc_scaled) begin
        // Carry the remainder, so an uneven ratio still keeps the mean rate
        step_acc = step_acc - acc_scaled;
        nxt_cur.bias_acc = (step_acc < acc_scaled) ? step_acc : 32'h0;
        nxt_cur.bias_buf = cur_ff.bias_buf + 16'h0001;
      end else begin
        nxt_cur.bias_acc = step_acc;
      end
    end else if (seq.bias_lower && !seq.bias_raise) begin
      step_acc = cur_ff.bias_acc + `FULL_SCALE;
      if (step_acc >= dec_scaled) begin
        // Same carry as on the raise side; at most one count a cycle
        step_acc = step_acc - dec_scaled;
        nxt_cur.bias_acc = (step_acc < dec_scaled) ? step_acc : 32'h0;
        nxt_cur.bias_buf = cur_ff.bias_buf - 16'h0001;
      end else begin
        nxt_cur.bias_acc = step_acc;
      end
    end else begin
      nxt_cur.bias_acc = 32'h0;
    end
    // Output ramp: slope grows by one per step up to the S limit.
    // With no S time the slope is one step at once; S shaping trades a
    // softer start for a peak rate that the user must keep sane.
    smax = (cur_ff.scurve == 16'h0) ? 16'h0001 : 16'h0002;
    step_acc = cur_ff.ramp_acc + `FULL_SCALE;
    if (skipped > cur_ff.out_ff) begin
      nxt_cur.dir = RAMP_UP;
      if (step_acc >= acc_scaled) begin
        // Carry the remainder so the sweep time follows the ramp setting
        step_acc = step_acc - acc_scaled;
        nxt_cur.ramp_acc = (step_acc < acc_scaled) ? step_acc : 32'h0;
        step = (cur_ff.dir == RAMP_UP && cur_ff.slope < smax) ? cur_ff.slope + 16'h1
             : (cur_ff.dir == RAMP_UP ? cur_ff.slope : 16'h0001);
        if (skipped - cur_ff.out_ff < step) begin
          step = skipped - cur_ff.out_ff;
        end
        nxt_cur.slope = step;
        nxt_cur.out_ff = cur_ff.out_ff + step;
      end else begin
        nxt_cur.ramp_acc = step_acc;
      end
    end else if (skipped < cur_ff.out_ff) begin
      nxt_cur.dir = RAMP_DOWN;
      if (step_acc >= dec_scaled) begin
        // Same carry on the way down
        step_acc = step_acc - dec_scaled;
        nxt_cur.ramp_acc = (step_acc < dec_scaled) ? step_acc : 32'h0;
        step = (cur_ff.dir == RAMP_DOWN && cur_ff.slope < smax) ? cur_ff.slope + 16'h1
             : (cur_ff.dir == RAMP_DOWN ? cur_ff.slope : 16'h0001);
        if (cur_ff.out_ff - skipped < step) begin
          step = cur_ff.out_ff - skipped;
        end
        nxt_cur.slope = step;
        nxt_cur.out_ff = cur_ff.out_ff - step;
      end else begin
        nxt_cur.ramp_acc = step_acc;
      end
    end else begin
      nxt_cur.dir = RAMP_IDLE;
      nxt_cur.slope = 16'h0000;
      nxt_cur.ramp_acc = 32'h0;
    end
    // APB address decode
    case (paddr)
      `REG_CTRL, `REG_STATUS, `REG_RATIO_COEF, `REG_RATIO_BIAS, `REG_EXTRA_BIAS,
      `REG_RAMP_ACC1, `REG_RAMP_DEC1, `REG_RAMP_ACC2, `REG_RAMP_DEC2, `REG_RAMP_JOGA,
      `REG_RAMP_JOGD, `REG_SCURVE, `REG_TIME_UNIT, `REG_SKIP_LO, `REG_SKIP_HI,
      `REG_SETTING_IN, `REG_COMMAND, `REG_BIAS_BUF, `REG_TM1, `REG_TM2, `REG_TM_SEL: hit = 1'b1;
      default: hit = (paddr[11:5] == `REG_PRESET0 >> 5) && (paddr[1:0] == 2'h0);
    endcase
    // Read data latched in setup, stable through access
    if (rd_en) begin
      case (paddr)
        `REG_CTRL: nxt_cur.rdata = cur_ff.ctrl;
        `REG_STATUS: nxt_cur.rdata = {27'h0, cur_ff.dir, cur_ff.latest};
        `REG_RATIO_COEF: nxt_cur.rdata = {16'h0, cur_ff.coef};
        `REG_RATIO_BIAS: nxt_cur.rdata = {16'h0, cur_ff.ratio_bias};
        `REG_EXTRA_BIAS: nxt_cur.rdata = {16'h0, cur_ff.extra_bias};
        `REG_RAMP_ACC1: nxt_cur.rdata = {16'h0, cur_ff.acc1};
        `REG_RAMP_DEC1: nxt_cur.rdata = {16'h0, cur_ff.dec1};
        `REG_RAMP_ACC2: nxt_cur.rdata = {16'h0, cur_ff.acc2};
        `REG_RAMP_DEC2: nxt_cur.rdata = {16'h0, cur_ff.dec2};
        `REG_RAMP_JOGA: nxt_cur.rdata = {16'h0, cur_ff.jog_acc};
        `REG_RAMP_JOGD: nxt_cur.rdata = {16'h0, cur_ff.jog_dec};
        `REG_SCURVE: nxt_cur.rdata = {16'h0, cur_ff.scurve};
        `REG_TIME_UNIT: nxt_cur.rdata = {30'h0, cur_ff.unit};
        `REG_SKIP_LO: nxt_cur.rdata = {16'h0, cur_ff.skip_lo};
        `REG_SKIP_HI: nxt_cur.rdata = {16'h0, cur_ff.skip_hi};
        `REG_SETTING_IN: nxt_cur.rdata = {16'h0, cur_ff.setting_in};
        `REG_COMMAND: nxt_cur.rdata = {16'h0, cur_ff.out_ff};
        `REG_BIAS_BUF: nxt_cur.rdata = {16'h0, cur_ff.bias_buf};
        `REG_TM1: nxt_cur.rdata = {16'h0, cur_ff.tm1};
        `REG_TM2: nxt_cur.rdata = {16'h0, cur_ff.tm2};
        `REG_TM_SEL: nxt_cur.rdata = {16'h0, active_time_const};
        default: nxt_cur.rdata = hit ? {16'h0, cur_ff.preset[paddr[4:2]]} : 32'h0;
      endcase
    end
    // Writes take effect at the access edge
    if (wr_en) begin
      case (paddr)
        `REG_CTRL: nxt_cur.ctrl = {29'h0, pwdata[2:0]};
        `REG_RATIO_COEF: nxt_cur.coef = pwdata[15:0];
        `REG_RATIO_BIAS: nxt_cur.ratio_bias = pwdata[15:0];
        `REG_EXTRA_BIAS: nxt_cur.extra_bias = pwdata[15:0];
        `REG_RAMP_ACC1: nxt_cur.acc1 = pwdata[15:0];
        `REG_RAMP_DEC1: nxt_cur.dec1 = pwdata[15:0];
        `REG_RAMP_ACC2: nxt_cur.acc2 = pwdata[15:0];
        `REG_RAMP_DEC2: nxt_cur.dec2 = pwdata[15:0];
        `REG_RAMP_JOGA: nxt_cur.jog_acc = pwdata[15:0];
        `REG_RAMP_JOGD: nxt_cur.jog_dec = pwdata[15:0];
        `REG_SCURVE: nxt_cur.scurve = pwdata[15:0];
        `REG_TIME_UNIT: nxt_cur.unit = pwdata[1:0];
        `REG_SKIP_LO: nxt_cur.skip_lo = pwdata[15:0];
        `REG_SKIP_HI: nxt_cur.skip_hi = pwdata[15:0];
        `REG_SETTING_IN: nxt_cur.setting_in = pwdata[15:0];
        `REG_TM1: nxt_cur.tm1 = pwdata[15:0];
        `REG_TM2: nxt_cur.tm2 = pwdata[15:0];
        default: begin
          if (hit && paddr[11:5] == `REG_PRESET0 >> 5) begin
            nxt_cur.preset[paddr[4:2]] = pwdata[15:0];
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      // Clear all, then load the fields whose idle value is not zero
      cur_ff <= '0;
      cur_ff.ctrl <= `CTRL_RESET;
      cur_ff.coef <= 16'h0100;
      cur_ff.unit <= `UNIT_X1;
      cur_ff.acc1 <= `RAMP_TIME_RESET;
      cur_ff.dec1 <= `RAMP_TIME_RESET;
      cur_ff.acc2 <= `RAMP_TIME_RESET;
      cur_ff.dec2 <= `RAMP_TIME_RESET;
      cur_ff.jog_acc <= `RAMP_TIME_RESET;
      cur_ff.jog_dec <= `RAMP_TIME_RESET;
      cur_ff.latest <= 3'h0;
      cur_ff.dir <= RAMP_IDLE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

endmodule : speed_reference_generator

/* File: speed_ref_sva.sv */
// Port checker of the speed reference block
module speed_ref_sva #(
  parameter int unsigned RAMP_UNIT_CYC = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sequence lines and outputs
  input speed_ref_pkg::seq_in_t seq,
  input wire logic [15:0] speed_command,
  input wire logic [15:0] active_time_const
);
  import speed_ref_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic rd_setup_ff; // Read setup seen last edge
  always_ff @(posedge clock) begin
    rd_setup_ff <= rst_n && psel && !penable && !pwrite;
  end
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_quiet;
    !(psel && penable && pwrite) && $stable(seq.inertia_alt_pick);
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_ready;
    s_access |-> pready;
  endproperty
  property p_err_only_access;
    pslverr |-> psel && penable;
  endproperty
  property p_unmapped_err;
    (psel && penable && paddr[11:8] != 4'h0) |-> pslverr;
  endproperty
  property p_mapped_ok;
    (psel && penable && paddr <= 12'h050 && paddr[1:0] == 2'h0) |-> !pslverr;
  endproperty
  property p_prdata_stand;
    $changed(prdata) |-> rd_setup_ff;
  endproperty
  property p_reset_zero;
    $rose(rst_n) |-> speed_command == 16'h0 && prdata == 32'h0 && active_time_const == 16'h0;
  endproperty
  property p_cmd_range;
    speed_command <= 16'h2710;
  endproperty
  property p_cmd_step;
    $past(speed_command) <= speed_command + 16'h2 && speed_command <= $past(speed_command) + 16'h2;
  endproperty
  property p_tm_hold;
    s_quiet [*2] |-> $stable(active_time_const);
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_err_only_access: assert property (p_err_only_access) else $error("pslverr outside access");
  a_unmapped_err: assert property (p_unmapped_err) else $error("no pslverr on unmapped");
  a_mapped_ok: assert property (p_mapped_ok) else $error("pslverr on mapped");
  a_prdata_stand: assert property (p_prdata_stand) else $error("prdata moved without read");
  a_reset_zero: assert property (p_reset_zero) else $error("outputs not clear at reset");
  a_cmd_range: assert property (p_cmd_range) else $error("command above full scale");
  a_cmd_step: assert property (p_cmd_step) else $error("command jumped");
  a_tm_hold: assert property (p_tm_hold) else $error("time constant moved");
endmodule : speed_ref_sva
bind speed_reference_generator speed_ref_sva #(.RAMP_UNIT_CYC(RAMP_UNIT_CYC)) u_sva (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .seq(seq), .speed_command(speed_command), .active_time_const(active_time_const));

/* File: seq_ctrl_model.sv */
// Model of the external controller driving the sequence lines
module seq_ctrl_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Wanted levels and pacing
  input speed_ref_pkg::seq_in_t want,
  input wire logic slow,
  // Lines into the block
  output speed_ref_pkg::seq_in_t seq
);
  import speed_ref_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  seq_in_t stage_ff; // Extra stage for a slow controller
  // Lines change only after an edge, held as levels
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage_ff <= '0;
      seq <= '0;
    end else begin
      stage_ff <= want;
      seq <= slow ? stage_ff : want;
    end
  end
endmodule : seq_ctrl_model

/* File: test_speed_reference_generator.sv */
// Self-checking bench of the speed reference block
`include "speed_ref_cfg.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %0h want %0h", $time, (g), (e)); end end
module test_speed_reference_generator;
  timeunit 1ns;
  timeprecision 1ns;
  import speed_ref_pkg::*;
  localparam int unsigned RU = 10; // Short ramp unit for simulation
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, rng = 32'hecb0;
  logic pready, pslverr, er;
  seq_in_t want = '0, seq;
  logic [15:0] speed_command, active_time_const, pre [8], t1, t2;
  int n_mismatch = 0, n_checks = 0, cyc = 0, i, s, c, b, g;
  int alt [5] = '{0, 1, 1, 1, 1}, jg [5] = '{0, 0, 1, 0, 0};
  int un [5] = '{1, 1, 1, 2, 3}, rt [5] = '{100, 5000, 2500, 5000, 5000};
  speed_reference_generator #(.RAMP_UNIT_CYC(RU)) DUT (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .seq(seq),
    .speed_command(speed_command), .active_time_const(active_time_const));
  seq_ctrl_model u_ctrl (.clock(clock), .rst_n(rst_n), .want(want), .slow(slow), .seq(seq));
  // ----------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 95000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h0040_0007 : 32'h0);
  endfunction : lfsr
  // Expected command: scaled input plus biases, clamped to full scale
  function automatic logic [15:0] f_cmd(input int x, input int k, input int bb);
    int v;
    v = ((x * k) >>> 8) + bb;
    v = v < 0 ? 0 : (v > 10000 ? 10000 : v);
    return v[15:0];
  endfunction : f_cmd
  // Expected trim counts: one count per ramp step, at most one a cycle
  function automatic int f_gain(input int t, input int u, input int n);
    int thr;
    thr = t * (u == 1 ? 10 : (u == 2 ? 1 : 100)) * RU / 10;
    return (n * 10000 / thr > n) ? n : n * 10000 / thr;
  endfunction : f_gain
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Drive trim lines for n cycles, then read the bias buffer
  task automatic trim(input logic r, input logic l, input int n);
    want.bias_raise <= r;
    want.bias_lower <= l;
    repeat (n) @(posedge clock);
    want.bias_raise <= 1'b0;
    want.bias_lower <= 1'b0;
    repeat (6) @(posedge clock);
    apb(1'b0, `REG_BIAS_BUF, 32'h0);
  endtask : trim
  task automatic wait_cmd(input logic [15:0] e);
    int n;
    n = 0;
    while (speed_command !== e && n < 12000) begin
      @(posedge clock);
      n++;
    end
  endtask : wait_cmd
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, `REG_CTRL, 32'h0);
    `CHK(rd, `CTRL_RESET)
    apb(1'b0, `REG_RATIO_COEF, 32'h0);
    `CHK(rd, 32'h100)
    apb(1'b0, `REG_TIME_UNIT, 32'h0);
    `CHK(rd[1:0], `UNIT_X1)
    apb(1'b0, `REG_RAMP_ACC2, 32'h0);
    `CHK(rd[15:0], `RAMP_TIME_RESET)
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK(rd[2:0], 3'h0)
    apb(1'b0, 12'h100, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    $display("test registers done");
    want.run <= 1'b1;
    want.fixed_speed_enable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rng = lfsr(rng);
      pre[i] = {5'h0, rng[10:0]};
      apb(1'b1, `REG_PRESET0 + 12'(4 * i), {16'h0, pre[i]});
    end
    for (i = 7; i >= 0; i--) begin
      rng = lfsr(rng);
      {want.upper_group_line, want.preset_line_3} <= rng[1:0];
      {want.preset_line_2, want.preset_line_1, want.preset_line_0} <= i[2:0];
      slow <= rng[2];
      repeat (3) @(posedge clock);
      wait_cmd(pre[i]);
      `CHK(speed_command, pre[i])
      apb(1'b0, `REG_STATUS, 32'h0);
      `CHK(rd[2:0], i[2:0])
    end
    $display("test binary pick done");
    apb(1'b1, `REG_CTRL, {30'h0, `SEL_MODE_DIRECT});
    for (i = 0; i < 8; i++) begin
      want.upper_group_line <= i[2];
      {want.preset_line_3, want.preset_line_2, want.preset_line_1, want.preset_line_0} <=
        4'h1 << i[1:0];
      repeat (4) @(posedge clock);
      {want.preset_line_3, want.preset_line_2, want.preset_line_1, want.preset_line_0} <= 4'h0;
      repeat (4) @(posedge clock);
      apb(1'b0, `REG_STATUS, 32'h0);
      `CHK(rd[2:0], i[2:0])
    end
    {want.preset_line_1, want.preset_line_0} <= 2'h3;
    repeat (4) @(posedge clock);
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK(rd[2:0], 3'h7)
    $display("test direct pick done");
    want.fixed_speed_enable <= 1'b0;
    apb(1'b1, `REG_CTRL, 32'h1);
    for (i = 0; i < 4; i++) begin
      rng = lfsr(rng);
      s = i == 3 ? 9000 : rng[11:0];
      c = i == 3 ? 1024 : 128 + rng[19:12];
      b = rng[28:20];
      apb(1'b1, `REG_SETTING_IN, s);
      apb(1'b1, `REG_RATIO_COEF, c);
      apb(1'b1, `REG_RATIO_BIAS, b / 2);
      apb(1'b1, `REG_EXTRA_BIAS, b - b / 2);
      wait_cmd(f_cmd(s, c, b));
      `CHK(speed_command, f_cmd(s, c, b))
    end
    apb(1'b1, `REG_RATIO_BIAS, 32'h0);
    apb(1'b1, `REG_EXTRA_BIAS, 32'h0);
    apb(1'b1, `REG_RATIO_COEF, 32'h100);
    apb(1'b1, `REG_SKIP_LO, 32'd1000);
    apb(1'b1, `REG_SKIP_HI, 32'd2000);
    apb(1'b1, `REG_CTRL, 32'h5);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, `REG_SETTING_IN, i == 0 ? 32'd1400 : 32'd1600);
      wait_cmd(i == 0 ? 16'd1000 : 16'd2000);
      `CHK(speed_command, i == 0 ? 16'd1000 : 16'd2000)
    end
    apb(1'b1, `REG_CTRL, 32'h1);
    $display("test ratio and skip done");
    rng = lfsr(rng);
    t1 = rng[15:0];
    t2 = ~rng[31:16];
    // Time constants only pass through; the droop bound stays with the user
    apb(1'b1, `REG_TM1, {16'h0, t1});
    apb(1'b1, `REG_TM2, {16'h0, t2});
    want.inertia_alt_pick <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(active_time_const, t2)
    want.inertia_alt_pick <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(active_time_const, t1)
    $display("test inertia done");
    apb(1'b1, `REG_SCURVE, 32'h5);
    apb(1'b1, `REG_SETTING_IN, 32'd5000);
    wait_cmd(16'd5000);
    `CHK(speed_command, 16'd5000)
    $display("test s shape done");
    apb(1'b1, `REG_RAMP_ACC2, 32'd5000);
    apb(1'b1, `REG_RAMP_JOGA, 32'd2500);
    want.bias_trim_enable <= 1'b1;
    for (i = 0; i < 5; i++) begin
      apb(1'b1, `REG_TIME_UNIT, un[i]);
      want.alt_ramp_choose <= alt[i][0];
      want.jog <= jg[i][0];
      trim(1'b1, 1'b0, 40);
      g = f_gain(rt[i], un[i], 40) - int'($signed(rd[15:0]));
      `CHK(g >= -2 && g <= 2, 1'b1)
      want.bias_trim_enable <= 1'b0;
      trim(1'b1, 1'b0, 8);
      `CHK(rd, 32'h0)
      want.bias_trim_enable <= 1'b1;
    end
    apb(1'b1, `REG_TIME_UNIT, 32'h1);
    want.alt_ramp_choose <= 1'b0;
    want.jog <= 1'b0;
    trim(1'b1, 1'b0, 40);
    b = int'($signed(rd[15:0]));
    trim(1'b0, 1'b0, 10);
    `CHK(int'($signed(rd[15:0])), b)
    trim(1'b0, 1'b1, 10);
    g = b - 10 - int'($signed(rd[15:0]));
    `CHK(g >= -2 && g <= 2, 1'b1)
    want.run <= 1'b0;
    trim(1'b1, 1'b0, 8);
    `CHK(rd, 32'h0)
    $display("test bias trim done");
    report_and_stop();
  end
endmodule : test_speed_reference_generator
